// File: gpio8_eint.sv
// external interrupt detection: per-vector sensitivity and pending latch
// assumes synchronised pin levels and per-pin interrupt enables from the port logic
`timescale 1ns/1ps
module gpio8_eint (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [47:0] pin_lvl,
  input  wire logic [47:0] irq_en,
  input  wire logic [7:0]  sens,
  input  wire logic        sens_wr,
  input  wire logic [3:0]  irq_ack,
  output logic      [3:0]  pend
);
  logic [47:0] prev;
  logic [47:0] hit;
  logic [3:0]  ev;

  // previous level for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= '0;
    end else if (clk_en) begin
      prev <= pin_lvl;
    end
  end

  // detect each pin with its vector's sensitivity, then or per vector
  always_comb begin
    hit = '0;
    ev  = '0;
    for (int v = 0; v < 4; v++) begin
      for (int i = 0; i < 48; i++) begin
        if (gpio8_pkg::EV_GROUP[v][i]) begin
          case (sens[2*v +: 2])
            gpio8_pkg::SENS_LOW:  hit[i] = !pin_lvl[i];
            gpio8_pkg::SENS_RISE: hit[i] = pin_lvl[i] && !prev[i];
            gpio8_pkg::SENS_FALL: hit[i] = !pin_lvl[i] && prev[i];
            default:              hit[i] = pin_lvl[i] ^ prev[i];
          endcase
        end
      end
      ev[v] = |(hit & irq_en & gpio8_pkg::EV_GROUP[v]);
    end
  end

  // pending latch: a new event wins over vector fetch or a sensitivity write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend <= '0;
    end else if (clk_en) begin
      for (int v = 0; v < 4; v++) begin
        if (ev[v]) begin
          pend[v] <= 1'b1;
        end else if (irq_ack[v] || sens_wr) begin
          pend[v] <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge aclk iff clk_en); endclocking
  default disable iff (!aresetn);

  a_edge_pend: assert property (|ev |=> ((pend & $past(ev)) == $past(ev)))
    else $error("detected event did not set its pending latch");
  a_sens_clear: assert property (sens_wr && ev == 4'h0 |=> pend == 4'h0)
    else $error("sensitivity write did not clear pending requests");
endmodule

// File: gpio8_pin_model.sv
// external circuitry on the 48 gpio pins: outside drivers, pull-ups, floating lines
// assumes the device pad controls change only just after rising edges of aclk
`timescale 1ns/1ps
module gpio8_pin_model (
  input  wire logic        aclk,
  input  wire logic [47:0] pin_out,
  input  wire logic [47:0] pin_oe,
  input  wire logic [47:0] pull_up_en,
  input  wire logic [47:0] ext_en,
  input  wire logic [47:0] ext_val,
  output logic      [47:0] pin_lvl
);
  logic [47:0] last_lvl;

  // remember the level so that an undriven, unpulled line flips every cycle
  always_ff @(posedge aclk) begin
    last_lvl <= pin_lvl;
  end

  // device drive wins, then the outside driver, then the pull-up, else the line floats
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
                   (~pin_oe & ~ext_en & (pull_up_en | ~last_lvl));
endmodule

// File: gpio8_pkg.sv
// constants for the six-port 8-bit gpio block: register indices, pin masks, codes
// assumes port a sits in pin bits 7:0 and port f in bits 47:40 of every 48-bit vector
package gpio8_pkg;
  // register indices; the byte address is four times the index
  localparam logic [4:0] IDX_PA_VAL = 5'h00;
  localparam logic [4:0] IDX_PA_DIR = 5'h01;
  localparam logic [4:0] IDX_PA_OPT = 5'h02;
  localparam logic [4:0] IDX_PB_VAL = 5'h03;
  localparam logic [4:0] IDX_PB_DIR = 5'h04;
  localparam logic [4:0] IDX_PB_OPT = 5'h05;
  localparam logic [4:0] IDX_PC_VAL = 5'h06;
  localparam logic [4:0] IDX_PC_DIR = 5'h07;
  localparam logic [4:0] IDX_PC_OPT = 5'h08;
  localparam logic [4:0] IDX_PD_VAL = 5'h09;
  localparam logic [4:0] IDX_PD_DIR = 5'h0A;
  localparam logic [4:0] IDX_PD_OPT = 5'h0B;
  localparam logic [4:0] IDX_PE_VAL = 5'h0C;
  localparam logic [4:0] IDX_PE_DIR = 5'h0D;
  localparam logic [4:0] IDX_PE_OPT = 5'h0E;
  localparam logic [4:0] IDX_PF_VAL = 5'h0F;
  localparam logic [4:0] IDX_PF_DIR = 5'h10;
  localparam logic [4:0] IDX_PF_OPT = 5'h11;
  localparam logic [4:0] IDX_SENS   = 5'h12;
  localparam logic [5:0] NREG       = 6'h13;
  localparam int         NPORT_REG  = 18;
  localparam int         PORT_STRIDE = 3;
  localparam int         ADDR_LSB   = 2;
  // reset values
  localparam logic [7:0] PORT_RST   = 8'h00;
  localparam logic [7:0] SENS_RST   = 8'h00;
  // pin classes
  localparam logic [47:0] IMPL_MASK = 48'hD7_03_3F_FF_1F_F8;
  localparam logic [47:0] TOD_MASK  = 48'h00_00_00_00_00_C0;
  localparam logic [47:0] PULL_MASK = 48'hD3_03_3F_FF_17_30;
  localparam logic [47:0] IRQ_PULL  = 48'h03_00_00_00_17_00;
  localparam logic [47:0] IRQ_FLOAT = 48'h04_00_00_00_08_08;
  // pins feeding each external interrupt vector, vector 3 down to 0
  localparam logic [3:0][47:0] EV_GROUP = {48'h00_00_00_00_17_00, 48'h00_00_00_00_08_00,
                                           48'h07_00_00_00_00_00, 48'h00_00_00_00_00_08};
  // sensitivity codes, two bits per vector
  localparam logic [1:0] SENS_LOW  = 2'h0;
  localparam logic [1:0] SENS_RISE = 2'h1;
  localparam logic [1:0] SENS_FALL = 2'h2;
  localparam logic [1:0] SENS_BOTH = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: gpio8_port_set.sv
// six 8-bit gpio ports behind an axi4-lite slave, with external interrupt vectors
// assumes pads resolve pin_out/pin_oe/pull_up_en; pin_in is asynchronous
`timescale 1ns/1ps
module gpio8_port_set (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [47:0] pin_in,
  output logic      [47:0] pin_out,
  output logic      [47:0] pin_oe,
  output logic      [47:0] pull_up_en,
  input  wire logic [47:0] alt_en,
  input  wire logic [47:0] alt_drive,
  input  wire logic [47:0] alt_out,
  output logic      [47:0] alt_in,
  input  wire logic        irq_mask,
  input  wire logic [3:0]  irq_ack,
  output logic      [3:0]  irq_req,
  output logic             wake_req
);
  logic [7:0]  regs [gpio8_pkg::NPORT_REG];
  logic [7:0]  ext_irq_sensitivity_ctrl;
  logic [47:0] lat48;
  logic [47:0] dir48;
  logic [47:0] opt48;
  logic [47:0] pin_sync;
  logic [47:0] rd48;
  logic [47:0] irq_en;
  logic [47:0] next_out;
  logic [47:0] next_oe;
  logic [47:0] next_pull;
  logic [3:0]  pend;
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic [5:0]  wr_dec;
  logic [5:0]  rd_dec;
  logic        sens_wr;
  logic [31:0] rd_word;

  // index and hit flag for an address: bit 5 set when mapped
  function automatic logic [5:0] reg_decode(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:gpio8_pkg::ADDR_LSB];
    if (addr[1:0] != 2'h0) begin
      reg_decode = 6'h00;
    end else if (idx < gpio8_pkg::NREG) begin
      reg_decode = {1'b1, idx[4:0]};
    end else begin
      reg_decode = 6'h00;
    end
  endfunction

  // the port's eight bits of a pin-wide vector, chosen by register index
  function automatic logic [7:0] port_slice(input logic [4:0] idx, input logic [47:0] v);
    int p;
    p = int'(idx) / gpio8_pkg::PORT_STRIDE;
    port_slice = v[p*8 +: 8];
  endfunction

  // pin levels pass two flops before any use
  gpio8_sync #(
    .WIDTH   (48)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clk_en   (clk_en),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // external interrupt detection and pending latches
  gpio8_eint u_eint (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .pin_lvl (pin_sync),
    .irq_en  (irq_en),
    .sens    (ext_irq_sensitivity_ctrl),
    .sens_wr (sens_wr),
    .irq_ack (irq_ack),
    .pend    (pend)
  );

  // flatten the register triples into pin-wide vectors
  always_comb begin
    lat48 = '0;
    dir48 = '0;
    opt48 = '0;
    for (int p = 0; p < 6; p++) begin
      lat48[p*8 +: 8] = regs[p*gpio8_pkg::PORT_STRIDE];
      dir48[p*8 +: 8] = regs[p*gpio8_pkg::PORT_STRIDE + 1];
      opt48[p*8 +: 8] = regs[p*gpio8_pkg::PORT_STRIDE + 2];
    end
  end

  // per-pin drive, pull and interrupt mode
  always_comb begin
    next_out  = '0;
    next_oe   = '0;
    next_pull = '0;
    irq_en    = '0;
    for (int i = 0; i < 48; i++) begin
      if (alt_en[i] && alt_drive[i]) begin
        next_oe[i]  = !gpio8_pkg::TOD_MASK[i] || !alt_out[i]; // peripheral takes the pin
        next_out[i] = alt_out[i] && !gpio8_pkg::TOD_MASK[i];
      end else if (dir48[i] && !alt_en[i]) begin
        if (gpio8_pkg::TOD_MASK[i] || !opt48[i]) begin
          next_oe[i] = !lat48[i]; // sink only, never drive high
        end else begin
          next_oe[i]  = 1'b1; // push-pull
          next_out[i] = lat48[i];
        end
      end else begin
        next_pull[i] = opt48[i] && gpio8_pkg::PULL_MASK[i];
        irq_en[i]    = opt48[i] && !alt_en[i] && (gpio8_pkg::IRQ_PULL[i] || gpio8_pkg::IRQ_FLOAT[i]);
      end
    end
  end

  // pad controls from flops; low power has no effect on them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      pull_up_en <= '0;
    end else if (clk_en) begin
      pin_out    <= next_out & gpio8_pkg::IMPL_MASK;
      pin_oe     <= next_oe & gpio8_pkg::IMPL_MASK;
      pull_up_en <= next_pull & gpio8_pkg::IMPL_MASK;
    end
  end

  // synchronised pin levels for peripherals reading pins
  assign alt_in = pin_sync;

  // interrupt gating by the processor mask; any request wakes from wait or halt
  assign irq_req  = pend & {4{!irq_mask}};
  assign wake_req = |irq_req;

  // write address and data are taken in either order
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign wr_go         = aw_got && w_got;
  assign wr_dec        = reg_decode(aw_addr);
  assign sens_wr       = wr_go && wr_dec[5] && w_strb[0] && wr_dec[4:0] == gpio8_pkg::IDX_SENS;

  // write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      aw_addr <= 8'h00;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_got <= 1'b0;
      end
    end
  end

  // write data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got  <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_got <= 1'b0;
      end
    end
  end

  // write response, error for an unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpio8_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_dec[5] ? gpio8_pkg::RESP_OKAY : gpio8_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // port registers; value writes always reach the latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int r = 0; r < gpio8_pkg::NPORT_REG; r++) begin
        regs[r] <= gpio8_pkg::PORT_RST;
      end
    end else if (clk_en) begin
      if (wr_go && wr_dec[5] && w_strb[0] && wr_dec[4:0] != gpio8_pkg::IDX_SENS) begin
        regs[wr_dec[4:0]] <= w_data[7:0] & port_slice(wr_dec[4:0], gpio8_pkg::IMPL_MASK);
      end
    end
  end

  // sensitivity register; writing it also drops pending requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_irq_sensitivity_ctrl <= gpio8_pkg::SENS_RST;
    end else if (clk_en) begin
      if (sens_wr) begin
        ext_irq_sensitivity_ctrl <= w_data[7:0];
      end
    end
  end

  // value readback: latch in output, peripheral output if it drives a pin in input, else the pin
  always_comb begin
    rd48 = '0;
    for (int i = 0; i < 48; i++) begin
      if (dir48[i]) begin
        rd48[i] = lat48[i];
      end else if (alt_en[i] && alt_drive[i]) begin
        rd48[i] = alt_out[i];
      end else begin
        rd48[i] = pin_sync[i];
      end
    end
    rd48 = rd48 & gpio8_pkg::IMPL_MASK;
  end

  // read word selection
  assign rd_dec = reg_decode(s_axi_araddr);
  always_comb begin
    rd_word = 32'h0000_0000;
    if (!rd_dec[5]) begin
      rd_word = 32'h0000_0000;
    end else if (rd_dec[4:0] == gpio8_pkg::IDX_SENS) begin
      rd_word[7:0] = ext_irq_sensitivity_ctrl;
    end else if (int'(rd_dec[4:0]) % gpio8_pkg::PORT_STRIDE == 0) begin
      rd_word[7:0] = port_slice(rd_dec[4:0], rd48);
    end else begin
      rd_word[7:0] = regs[rd_dec[4:0]];
    end
  end

  // read channel: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= gpio8_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_dec[5] ? gpio8_pkg::RESP_OKAY : gpio8_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  logic [47:0] pp_sel;
  logic [47:0] od_sel;
  logic [47:0] alt_sel;
  assign pp_sel  = dir48 & opt48 & ~gpio8_pkg::TOD_MASK & ~alt_en & gpio8_pkg::IMPL_MASK;
  assign od_sel  = dir48 & (~opt48 | gpio8_pkg::TOD_MASK) & ~alt_en & gpio8_pkg::IMPL_MASK;
  assign alt_sel = alt_en & alt_drive & gpio8_pkg::IMPL_MASK & ~gpio8_pkg::TOD_MASK;

  default clocking cb @(posedge aclk iff clk_en); endclocking
  default disable iff (!aresetn);

  sequence s_aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp_ready;
    ##2 s_axi_bvalid;
  endsequence

  a_pp_drive: assert property (((pin_oe & $past(pp_sel)) == $past(pp_sel))
                               && (((pin_out ^ $past(lat48)) & $past(pp_sel)) == 48'h0))
    else $error("push-pull pin not driving its latch");
  a_od_drive: assert property (((pin_oe ^ ~$past(lat48)) & $past(od_sel)) == 48'h0)
    else $error("open-drain pin sink does not follow latch");
  a_tod_high: assert property ((pin_oe & pin_out & gpio8_pkg::TOD_MASK) == 48'h0)
    else $error("true open-drain pin driven high");
  a_pull_sel: assert property (pull_up_en ==
                               ($past(~(dir48 & ~alt_en) & opt48 & ~alt_sel) & gpio8_pkg::PULL_MASK))
    else $error("pull-up enable does not match input mode");
  a_alt_wins: assert property (((pin_oe & $past(alt_sel)) == $past(alt_sel))
                               && (((pin_out ^ $past(alt_out)) & $past(alt_sel)) == 48'h0))
    else $error("alternate function not driving its pin");
  a_irq_gate: assert property (irq_mask |-> irq_req == 4'h0 && !wake_req)
    else $error("interrupt forwarded while masked");
  a_unimpl_zero: assert property (((lat48 | dir48 | opt48) & ~gpio8_pkg::IMPL_MASK) == 48'h0)
    else $error("unimplemented bit stored");
  a_write_resp: assert property (s_aw_w_taken |-> s_resp_ready)
    else $error("write response not given two cycles after address and data");
endmodule

// File: gpio8_sync.sv
// two-stage synchroniser for pin levels coming from outside the clock domain
// assumes a single clock; the first stage is read only by the second
`timescale 1ns/1ps
module gpio8_sync #(
  parameter int WIDTH = 48
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // two flops in series, frozen while the clock enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// File: gpio8_tb.sv
// self-checking bench for the six-port gpio block over axi4-lite
// assumes gpio8_pkg, gpio8_port_set and gpio8_pin_model are compiled first
`timescale 1ns/1ps
module testbench;
  localparam logic [1:0] OK  = gpio8_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = gpio8_pkg::RESP_SLVERR;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq_mask;
  logic        awready, wready, bvalid, arready, rvalid, wake_req;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  irq_ack, irq_req;
  logic [47:0] ext_en, ext_val, alt_en, alt_drive, alt_out, alt_in, pin_lvl, pin_out, pin_oe, pull_up_en;
  int          fail_count, cmp_count;

  gpio8_port_set i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_up_en(pull_up_en), .alt_en(alt_en), .alt_drive(alt_drive),
    .alt_out(alt_out), .alt_in(alt_in), .irq_mask(irq_mask), .irq_ack(irq_ack),
    .irq_req(irq_req), .wake_req(wake_req));

  gpio8_pin_model i_pins (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

  // 25 MHz clock
  always #20 aclk = ~aclk;

  // compare and count
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one axi write; byte address is four times the register index
  task automatic wr(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic       a, w, b, fin;
    logic [1:0] r;
    @(posedge aclk);
    awaddr  <= {1'b0, idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fin = 1'b0;
    while (!fin) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        fin = 1'b1;
      end
    end
    chk(48'(r), 48'(er));
  endtask

  // one axi read, compared with the expected byte and response
  task automatic rd(input logic [4:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic        a, fin;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    araddr  <= {1'b0, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    fin = 1'b0;
    while (!fin) begin
      @(negedge aclk);
      a = arvalid && arready;
      fin = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (fin) rready <= 1'b0;
    end
    chk(48'(d), 48'(ed));
    chk(48'(r), 48'(er));
  endtask

  // wait n edges, then look at settled outputs mid-cycle
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // outside driver on one pin
  task automatic drv(input int b, input logic e, input logic v);
    @(posedge aclk);
    ext_en[b]  <= e;
    ext_val[b] <= v;
  endtask

  // one-cycle vector fetch pulse
  task automatic ack(input logic [3:0] m);
    @(posedge aclk);
    irq_ack <= m;
    @(posedge aclk);
    irq_ack <= 4'h0;
  endtask

  // verdict and end of run
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #800000;
    fail_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; irq_mask = 1'b0; irq_ack = 4'h0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    ext_en = '1; ext_val = '0; alt_en = '0; alt_drive = '0; alt_out = '0;
    fail_count = 0; cmp_count = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // every port register starts at zero; outside drivers hold all pins low
    for (int i = 0; i < 18; i++) rd(5'(i), 8'h00, OK);
    wr(5'h13, 8'h55, ERR);
    rd(5'h13, 8'h00, ERR);
    // latch written while input: pin untouched, read shows the pin
    @(posedge aclk);
    ext_val <= 48'h00_00_00_3C_00_08;
    wr(gpio8_pkg::IDX_PC_VAL, 8'hA5, OK);
    wt(3);
    chk(48'(pin_oe[23:16]), 48'h0);
    rd(gpio8_pkg::IDX_PC_VAL, 8'h3C, OK);
    // all four standard modes on port c
    for (int m = 0; m < 4; m++) begin
      wr(gpio8_pkg::IDX_PC_DIR, m[1] ? 8'hFF : 8'h00, OK);
      wr(gpio8_pkg::IDX_PC_OPT, m[0] ? 8'hFF : 8'h00, OK);
      wt(1);
      chk(48'(pin_oe[23:16]), (m == 3) ? 48'hFF : (m == 2) ? 48'h5A : 48'h0);
      chk(48'(pull_up_en[23:16]), (m == 1) ? 48'hFF : 48'h0);
      chk(48'(pin_out[23:16] & pin_oe[23:16]), (m == 3) ? 48'hA5 : 48'h0);
    end
    rd(gpio8_pkg::IDX_PC_VAL, 8'hA5, OK);
    wr(gpio8_pkg::IDX_PC_DIR, 8'h00, OK);
    // port e has two pins only
    wr(gpio8_pkg::IDX_PE_DIR, 8'hFF, OK);
    rd(gpio8_pkg::IDX_PE_DIR, 8'h03, OK);
    wt(1);
    chk(48'(pin_oe[39:32]), 48'h03);
    wr(gpio8_pkg::IDX_PE_DIR, 8'h00, OK);
    // port a bits 7:6 never drive high and never pull up
    wr(gpio8_pkg::IDX_PA_VAL, 8'hC0, OK);
    wr(gpio8_pkg::IDX_PA_OPT, 8'hC0, OK);
    wr(gpio8_pkg::IDX_PA_DIR, 8'hC0, OK);
    wt(1);
    chk(48'(pin_oe[7:6]), 48'h0);
    wr(gpio8_pkg::IDX_PA_DIR, 8'h00, OK);
    wt(1);
    chk(48'(pull_up_en[7:6]), 48'h0);
    wr(gpio8_pkg::IDX_PA_VAL, 8'h00, OK);
    wr(gpio8_pkg::IDX_PA_DIR, 8'hC0, OK);
    wt(1);
    chk(48'({pin_oe[7:6], pin_out[7:6]}), 48'hC);
    wr(gpio8_pkg::IDX_PA_DIR, 8'h00, OK);
    // pin a3 as floating interrupt input, every sensitivity code
    wr(gpio8_pkg::IDX_PA_OPT, 8'h08, OK);
    wt(1);
    chk(48'(pull_up_en[3]), 48'h0);
    for (int c = 0; c < 4; c++) begin
      wr(gpio8_pkg::IDX_SENS, 8'(c), OK);
      wt(4);
      chk(48'(irq_req), 48'h0);
      drv(3, 1'b1, 1'b0);
      wt(4);
      chk(48'(irq_req[0]), 48'(c != 1));
      ack(4'h1);
      drv(3, 1'b1, 1'b1);
      wt(4);
      chk(48'(irq_req[0]), 48'(c != 2));
      ack(4'h1);
    end
    // masked event waits, then wakes once unmasked
    wr(gpio8_pkg::IDX_SENS, 8'h02, OK);
    @(posedge aclk);
    irq_mask <= 1'b1;
    drv(3, 1'b1, 1'b0);
    wt(4);
    chk(48'({irq_req, wake_req}), 48'h0);
    @(posedge aclk);
    irq_mask <= 1'b0;
    wt(0);
    chk(48'({irq_req, wake_req}), 48'h3);
    ack(4'h1);
    drv(3, 1'b1, 1'b1);
    // port b vector shared by four pulled pins; b0 left floating and not armed
    @(posedge aclk);
    ext_en[15:8] <= 8'h00;
    wr(gpio8_pkg::IDX_PB_OPT, 8'h16, OK);
    wt(1);
    chk(48'(pull_up_en[15:8]), 48'h16);
    wr(gpio8_pkg::IDX_SENS, 8'h80, OK);
    wt(6);
    chk(48'(irq_req), 48'h0);
    drv(9, 1'b1, 1'b0);
    wt(4);
    chk(48'(irq_req), 48'h8);
    ack(4'h8);
    drv(9, 1'b0, 1'b0);
    drv(12, 1'b1, 1'b0);
    wt(4);
    chk(48'(irq_req), 48'h8);
    ack(4'h8);
    drv(12, 1'b0, 1'b0);
    // peripheral takes pin d0 while the port says floating input
    wr(gpio8_pkg::IDX_PD_OPT, 8'h00, OK);
    @(posedge aclk);
    alt_en[24]    <= 1'b1;
    alt_drive[24] <= 1'b1;
    alt_out[24]   <= 1'b1;
    ext_en[24]    <= 1'b0;
    ext_val[25]   <= 1'b1;
    wt(3);
    chk(48'({pin_oe[24], pin_out[24], alt_in[25]}), 48'h7);
    rd(gpio8_pkg::IDX_PD_VAL, 8'h03, OK);
    // reset in mid-run clears registers that were written
    @(posedge aclk);
    alt_en    <= '0;
    alt_drive <= '0;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(gpio8_pkg::IDX_PC_OPT, 8'h00, OK);
    rd(gpio8_pkg::IDX_PB_OPT, 8'h00, OK);
    rd(gpio8_pkg::IDX_SENS, 8'h00, OK);
    wt(0);
    chk(pull_up_en, 48'h0);
    wrap_up();
  end
endmodule
